// ---- verilog/sciss_top.sv ----
/*
 * Interrupt cause, sequence step, selection timeout and synchronous pacing
 * registers, reached over a classic Wishbone slave with 32-bit data.
 * Assumes the protocol engine posts finished sequences as one-cycle pulses
 * on clk_i; bus-side event pins are asynchronous and are synchronised here.
 */
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module sciss_top
	import sciss_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// wishbone slave
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [SCISS_ADDR_W-1:0] adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	// engine side
	input  wire logic                    target_mode_i,
	input  wire logic                    cmd_write_i,
	input  wire logic                    cmd_illegal_i,
	input  wire logic                    atn_i,
	input  wire sciss_seq_evt_t          seq_evt_i,
	input  wire sciss_bus_evt_t          bus_evt_i,
	input  wire logic                    tx_byte_i,
	input  wire logic                    ack_in_i,
	input  wire logic                    fifo_pop_i,
	input  wire logic                    offset_clr_i,
	// outputs
	output logic                         irq_o,
	output logic                         atn_hold_o,
	output logic      [7:0]              sel_timeout_o,
	output sciss_pace_t                  pace_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0]    dat;
		logic           ack;
		logic [7:0]     cause;
		logic [3:0]     step;
		logic           stat_irq;
		logic           no_rst_rep;
		logic [7:0]     timeout;
		logic [4:0]     period;
		logic [3:0]     offset;
		logic [4:0]     outstanding;
		logic           atn_hold;
		logic           rx_ack;
		logic [4:0]     s0;
		logic [4:0]     s1;
		logic [4:0]     s2;
		logic [4:0]     prev;
		logic           sync_mode;
		logic [5:0]     pclk;
	} sciss_state_t;

	sciss_state_t  st_q;
	sciss_state_t  st_d;
	sciss_report_t rep;

	sciss_step_dec u_dec (
		.unused_i (1'b0),
		.evt_i    (seq_evt_i),
		.rep_o    (rep)
	);

	// ---------------------------------------------------------------
	// combinational helpers
	// ---------------------------------------------------------------
	logic       req;
	logic       rd_cause;
	logic [3:0] idx;
	logic [4:0] pins_agree;
	logic [4:0] pins_rise;
	logic [4:0] pins_raw;
	logic [4:0] sync_lvl;
	logic [5:0] period_clk;

	assign req      = cyc_i && stb_i && !st_q.ack;
	assign idx      = adr_i[SCISS_ADDR_W-1:2];
	assign rd_cause = req && !we_i && idx == SCISS_IDX_CAUSE;
	assign pins_raw = {bus_evt_i.bus_reset, bus_evt_i.reselected,
		bus_evt_i.disconnected, bus_evt_i.info_req, bus_evt_i.msgin_req};

	// a pin counts only once the second and third stage agree
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_pin
			assign pins_agree[g] = st_q.s1[g] == st_q.s2[g];
			// a disagreeing pair keeps the last accepted level
			assign sync_lvl[g]   = pins_agree[g] ? st_q.s2[g] : st_q.prev[g];
		end
	endgenerate

	// codes 0..3 wrap to 32..35, 4 behaves as 5
	always_comb begin
		if (st_q.period < SCISS_PERIOD_MIN_CODE) begin
			period_clk = SCISS_PERIOD_WRAP + {1'b0, st_q.period};
		end else if (st_q.period == SCISS_PERIOD_MIN_CODE) begin
			period_clk = SCISS_PERIOD_MIN;
		end else begin
			period_clk = {1'b0, st_q.period};
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic [7:0] set_bits;
	logic [7:0] rd_byte;
	logic       pend;

	always_comb begin
		st_d     = st_q;
		set_bits = '0;
		rd_byte  = '0;
		pend     = |st_q.cause;

		// three-stage synchroniser on every event pin
		st_d.s0   = pins_raw;
		st_d.s1   = st_q.s0;
		st_d.s2   = st_q.s1;
		st_d.prev = sync_lvl;

		// bus answer, one cycle after the request, dropped the cycle after
		st_d.ack = req;
		if (req && !we_i) begin
			unique case (idx)
			SCISS_IDX_STATUS: rd_byte = {st_q.stat_irq, 7'h00};
			SCISS_IDX_CAUSE:  rd_byte = st_q.cause;
			SCISS_IDX_STEP:   rd_byte = {4'h0, st_q.step};
			SCISS_IDX_CTRL:   rd_byte = {7'h00, st_q.no_rst_rep};
			default:          rd_byte = 8'h00;
			endcase
		end
		st_d.dat = {24'h000000, rd_byte};

		if (req && we_i && sel_i[0]) begin
			unique case (idx)
			SCISS_IDX_CAUSE:  st_d.timeout    = dat_i[7:0];
			SCISS_IDX_OFFSET: st_d.offset     = dat_i[3:0];
			SCISS_IDX_PERIOD: st_d.period     = dat_i[4:0];
			SCISS_IDX_CTRL:   st_d.no_rst_rep = dat_i[SCISS_CTRL_NORST_BIT];
			default:          ;
			endcase
		end

		// read clears only when something was posted; software reads
		// status and step first because this wipes them
		if (rd_cause && pend) begin
			st_d.cause    = '0;
			st_d.step     = '0;
			st_d.stat_irq = 1'b0;
		end

		// event sources
		if (pins_rise[4] && !st_q.no_rst_rep) begin
			set_bits[SCISS_CAUSE_RST_BIT] = 1'b1;
		end
		if (cmd_write_i && cmd_illegal_i) begin
			set_bits[SCISS_CAUSE_ILL_BIT] = 1'b1;
		end
		if (!target_mode_i && pins_rise[2]) begin
			set_bits[SCISS_CAUSE_DISC_BIT] = 1'b1;
		end
		if (target_mode_i ? (atn_i && pins_rise[0]) : pins_rise[1]) begin
			set_bits[SCISS_CAUSE_SVC_BIT] = 1'b1;
		end
		if (!target_mode_i && pins_rise[0]) begin
			set_bits[SCISS_CAUSE_DONE_BIT] = 1'b1;
		end
		if (!target_mode_i && pins_rise[3]) begin
			set_bits[SCISS_CAUSE_RSEL_BIT] = 1'b1;
		end
		if (seq_evt_i.valid) begin
			// timeouts, terminations, selections and completions
			set_bits    = set_bits | rep.cause;
			st_d.step[2:0] = rep.step;
			st_d.atn_hold  = rep.atn_keep;
		end

		// set wins over the read clear
		if (|set_bits) begin
			st_d.cause    = st_d.cause | set_bits;
			st_d.stat_irq = 1'b1;
		end

		// synchronous offset tracking
		if (st_q.offset == SCISS_OFFSET_RST || offset_clr_i) begin
			st_d.outstanding = '0;
		end else if (tx_byte_i && !ack_in_i) begin
			st_d.outstanding = st_q.outstanding + 5'h01;
		end else if (ack_in_i && !tx_byte_i && st_q.outstanding != 5'h00) begin
			st_d.outstanding = st_q.outstanding - 5'h01;
		end
		st_d.step[SCISS_STEP_LIM_BIT] = st_q.offset != SCISS_OFFSET_RST
			&& st_d.outstanding >= {1'b0, st_q.offset};
		// one ack per byte leaving the receive fifo, only while the offset is nonzero
		st_d.rx_ack = fifo_pop_i && st_q.offset != SCISS_OFFSET_RST;
		st_d.sync_mode = st_d.offset != SCISS_OFFSET_RST;
		// decoded period lags the code by one cycle
		st_d.pclk = period_clk;
	end

	assign pins_rise = sync_lvl & ~st_q.prev;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q         <= '0;
			st_q.period  <= SCISS_PERIOD_RST;
			st_q.timeout <= SCISS_TIMEOUT_RST;
			st_q.pclk    <= {1'b0, SCISS_PERIOD_RST};
		end else begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign dat_o              = st_q.dat;
	assign ack_o              = st_q.ack;
	assign irq_o              = st_q.stat_irq;
	assign atn_hold_o         = st_q.atn_hold;
	assign sel_timeout_o      = st_q.timeout;
	assign pace_o.sync_mode   = st_q.sync_mode;
	assign pace_o.send_stall  = st_q.step[SCISS_STEP_LIM_BIT];
	assign pace_o.rx_ack      = st_q.rx_ack;
	assign pace_o.limit       = st_q.step[SCISS_STEP_LIM_BIT];
	assign pace_o.period      = st_q.pclk;

endmodule : sciss_top
`default_nettype wire

// ---- common/sciss_pkg.sv ----
/*
 * Constants and carrier types for the interrupt-cause and sequence-step block
 * of a parallel-bus storage protocol controller.
 * Assumes a byte-wide register set on classic Wishbone with one word per index.
 */
package sciss_pkg;

	// ---------------------------------------------------------------
	// register indices and address width
	// ---------------------------------------------------------------
	localparam logic [3:0] SCISS_IDX_STATUS = 4'h4;
	localparam logic [3:0] SCISS_IDX_CAUSE  = 4'h5;
	localparam logic [3:0] SCISS_IDX_STEP   = 4'h6;
	localparam logic [3:0] SCISS_IDX_OFFSET = 4'h7;
	localparam logic [3:0] SCISS_IDX_PERIOD = 4'hD;
	localparam logic [3:0] SCISS_IDX_CTRL   = 4'hE;
	localparam int         SCISS_ADDR_W     = 6;

	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int         SCISS_CAUSE_RST_BIT  = 7;
	localparam int         SCISS_CAUSE_ILL_BIT  = 6;
	localparam int         SCISS_CAUSE_DISC_BIT = 5;
	localparam int         SCISS_CAUSE_SVC_BIT  = 4;
	localparam int         SCISS_CAUSE_DONE_BIT = 3;
	localparam int         SCISS_CAUSE_RSEL_BIT = 2;
	localparam int         SCISS_CAUSE_SATN_BIT = 1;
	localparam int         SCISS_CAUSE_SEL_BIT  = 0;
	localparam int         SCISS_STAT_IRQ_BIT   = 7;
	localparam int         SCISS_STEP_LIM_BIT   = 3;
	localparam int         SCISS_CTRL_NORST_BIT = 0;
	localparam logic [4:0] SCISS_PERIOD_RST     = 5'h05;
	localparam logic [4:0] SCISS_PERIOD_MIN_CODE = 5'h04;
	localparam logic [5:0] SCISS_PERIOD_WRAP    = 6'h20;
	localparam logic [5:0] SCISS_PERIOD_MIN     = 6'h05;
	localparam logic [3:0] SCISS_OFFSET_RST     = 4'h0;
	localparam logic [7:0] SCISS_TIMEOUT_RST    = 8'h00;

	// cause patterns of the sequence tables
	localparam logic [7:0] SCISS_C_TIMEOUT   = 8'h20;
	localparam logic [7:0] SCISS_C_SVC_DONE  = 8'h18;
	localparam logic [7:0] SCISS_C_DONE      = 8'h08;
	localparam logic [7:0] SCISS_C_DISC_DONE = 8'h28;
	localparam logic [7:0] SCISS_C_SEL       = 8'h01;
	localparam logic [7:0] SCISS_C_SATN      = 8'h02;
	localparam logic [7:0] SCISS_C_SVC       = 8'h10;

	// ---------------------------------------------------------------
	// sequences and their end conditions
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SCISS_SQ_SEL_ATN_STOP = 4'h0,
		SCISS_SQ_SEL          = 4'h1,
		SCISS_SQ_SEL_ATN      = 4'h2,
		SCISS_SQ_SEL_ATN3     = 4'h3,
		SCISS_SQ_TGT_SEL      = 4'h4,
		SCISS_SQ_TGT_SEL_ATN  = 4'h5,
		SCISS_SQ_TGT_RXCMD    = 4'h6,
		SCISS_SQ_TGT_DISC     = 4'h7,
		SCISS_SQ_TGT_TERM     = 4'h8,
		SCISS_SQ_TGT_CCOMP    = 4'h9
	} sciss_seq_t;

	typedef enum logic [2:0] {
		SCISS_END_TIMEOUT = 3'h0,
		SCISS_END_NOPHASE = 3'h1,
		SCISS_END_PREMAT  = 3'h2,
		SCISS_END_PARITY  = 3'h3,
		SCISS_END_ATN     = 3'h4,
		SCISS_END_DONE    = 3'h5
	} sciss_end_t;

	// one finished sequence from the protocol engine
	typedef struct packed {
		logic       valid;
		sciss_seq_t seq;
		sciss_end_t how;
		logic [1:0] bytes;
		logic       atn;
	} sciss_seq_evt_t;

	// asynchronous bus events, pin level
	typedef struct packed {
		logic bus_reset;
		logic reselected;
		logic disconnected;
		logic info_req;
		logic msgin_req;
	} sciss_bus_evt_t;

	// synchronous pacing towards the transfer engine
	typedef struct packed {
		logic       sync_mode;
		logic       send_stall;
		logic       rx_ack;
		logic       limit;
		logic [5:0] period;
	} sciss_pace_t;

	// per-sequence result: step code and cause pattern
	typedef struct packed {
		logic [2:0] step;
		logic [7:0] cause;
		logic       atn_keep;
	} sciss_report_t;

endpackage : sciss_pkg

// ---- verilog/sciss_step_dec.sv ----
/*
 * Maps a finished sequence onto its step code, cause pattern and ATN hold.
 * Assumes the protocol engine reports one finished sequence at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module sciss_step_dec
	import sciss_pkg::*;
(
	input  wire logic           [0:0] unused_i,
	input  wire sciss_seq_evt_t       evt_i,
	output var  sciss_report_t        rep_o
);

	// ---------------------------------------------------------------
	// table lookup
	// ---------------------------------------------------------------
	always_comb begin
		rep_o          = '0;
		rep_o.cause    = SCISS_C_SVC_DONE;
		unique case (evt_i.seq)
		SCISS_SQ_SEL_ATN_STOP: begin
			if (evt_i.how == SCISS_END_TIMEOUT) begin
				rep_o.cause = SCISS_C_TIMEOUT;
			end else if (evt_i.how == SCISS_END_NOPHASE) begin
				rep_o.atn_keep = 1'b1;
			end else begin
				rep_o.step     = 3'h1;
				rep_o.atn_keep = 1'b1;
			end
		end
		SCISS_SQ_SEL, SCISS_SQ_SEL_ATN, SCISS_SQ_SEL_ATN3: begin
			unique case (evt_i.how)
			SCISS_END_TIMEOUT: rep_o.cause = SCISS_C_TIMEOUT;
			SCISS_END_NOPHASE: begin
				// with ATN: no message phase means step 000, ATN held
				if (evt_i.seq != SCISS_SQ_SEL && evt_i.bytes == 2'h0) begin
					rep_o.atn_keep = 1'b1;
				end else begin
					rep_o.step = 3'h2;
				end
				// three-byte select keeps ATN until the third byte went
				if (evt_i.seq == SCISS_SQ_SEL_ATN3 && evt_i.bytes != 2'h0
						&& evt_i.bytes != 2'h3) begin
					rep_o.atn_keep = 1'b1;
				end
			end
			SCISS_END_PREMAT:  rep_o.step = 3'h3;
			default:           rep_o.step = 3'h4;
			endcase
		end
		SCISS_SQ_TGT_SEL: begin
			rep_o.cause = evt_i.atn ? SCISS_C_SVC | SCISS_C_SEL : SCISS_C_SEL;
			if (evt_i.how == SCISS_END_PARITY) begin
				rep_o.step = 3'h1;
			end else if (evt_i.how == SCISS_END_DONE) begin
				rep_o.step = 3'h2;
			end
		end
		SCISS_SQ_TGT_SEL_ATN: begin
			rep_o.cause = evt_i.atn ? SCISS_C_SVC | SCISS_C_SATN : SCISS_C_SATN;
			if (evt_i.how == SCISS_END_PARITY && evt_i.bytes != 2'h0) begin
				rep_o.step = 3'h1;
			end else if (evt_i.how == SCISS_END_DONE) begin
				rep_o.step = 3'h2;
			end
		end
		SCISS_SQ_TGT_RXCMD: begin
			rep_o.cause = evt_i.atn ? SCISS_C_SVC_DONE : SCISS_C_DONE;
			rep_o.step  = (evt_i.how == SCISS_END_DONE) ? 3'h2 : 3'h1;
		end
		default: begin
			// disconnect, terminate, command complete
			if (evt_i.how == SCISS_END_DONE) begin
				rep_o.step  = 3'h2;
				rep_o.cause = SCISS_C_DISC_DONE;
			end else begin
				rep_o.step = (evt_i.bytes == 2'h2) ? 3'h1 : 3'h0;
			end
		end
		endcase
	end

endmodule : sciss_step_dec
`default_nettype wire

// ---- sim/sciss_bus_model.sv ----
/* Far side stand-in: finished protocol sequences and bus event pins.
 * Assumes callers resume just after a clk_i rising edge. */
`timescale 1ns/100ps
`default_nettype none
module sciss_bus_model
	import sciss_pkg::*;
(
	input  wire logic	clk_i,
	output var  sciss_seq_evt_t	seq_o,
	output var  sciss_bus_evt_t	bus_o
);
	initial begin
		seq_o = '0;
		bus_o = '0;
	end
	task automatic seq(input sciss_seq_t s, input sciss_end_t h, input logic [1:0] b,
		input logic a);
		@(posedge clk_i);
		seq_o <= '{1'b1, s, h, b, a};
		@(posedge clk_i);
		seq_o <= '0;
	endtask : seq
	// pins are levels; long holds catch a level-instead-of-edge slip
	task automatic pin(input int k, input int n);
		@(posedge clk_i);
		bus_o[k] <= 1'b1;
		repeat (n) @(posedge clk_i);
		bus_o[k] <= 1'b0;
	endtask : pin
endmodule : sciss_bus_model
`default_nettype wire

// ---- sim/sciss_properties.sv ----
/* Port checker for sciss_top, bound at the foot of this file.
 * Assumes one clock and no bus pin event during a cause read. */
`timescale 1ns/100ps
`default_nettype none
module sciss_properties
	import sciss_pkg::*;
(
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	cyc_i,
	input wire logic	stb_i,
	input wire logic	we_i,
	input wire logic [SCISS_ADDR_W-1:0]	adr_i,
	input wire logic [3:0]	sel_i,
	input wire logic [31:0]	dat_i,
	input wire logic	ack_o,
	input wire logic	cmd_write_i,
	input wire logic	cmd_illegal_i,
	input wire sciss_seq_evt_t	seq_evt_i,
	input wire logic	irq_o,
	input wire logic [7:0]	sel_timeout_o,
	input wire sciss_pace_t	pace_o
);
	logic	rd_cause;
	logic	wr_ok;
	assign rd_cause = cyc_i & stb_i & ~we_i & (adr_i[5:2] == SCISS_IDX_CAUSE);
	assign wr_ok = ack_o & we_i & sel_i[0];
	// codes below four wrap to the long periods
	function automatic logic [5:0] period_of(input logic [31:0] d);
		return (d[4:0] < 5'h04) ? {1'b1, d[4:0]} : (d[4:0] == 5'h04) ? 6'h05 : {1'b0, d[4:0]};
	endfunction : period_of
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged next cycle");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_IRQ_CLEAR: assert property (rd_cause && ack_o && !seq_evt_i.valid |=> !irq_o)
		else $error("irq survived a cause read");
	AST_IRQ_HOLD: assert property ($fell(irq_o) |-> $past(rd_cause) || $past(rd_cause, 2) || $past(rst_i))
		else $error("irq dropped without a cause read");
	AST_SEQ_POST: assert property (seq_evt_i.valid |-> ##[1:2] irq_o)
		else $error("sequence end not posted");
	AST_ILL_POST: assert property (cmd_write_i && cmd_illegal_i |-> ##[1:2] irq_o)
		else $error("illegal command not posted");
	AST_TIMEOUT_WR: assert property (wr_ok && adr_i[5:2] == SCISS_IDX_CAUSE |=>
		{24'h0, sel_timeout_o} == ($past(dat_i) & 32'h0000_00FF)) else $error("timeout not loaded");
	AST_PERIOD_WR: assert property (wr_ok && adr_i[5:2] == SCISS_IDX_PERIOD |=>
		pace_o.period == period_of($past(dat_i))) else $error("period decode wrong");
	AST_PERIOD_RST: assert property ($fell(rst_i) |-> pace_o.period == SCISS_PERIOD_MIN)
		else $error("period reset value wrong");
	AST_ASYNC_ZERO: assert property (wr_ok && adr_i[5:2] == SCISS_IDX_OFFSET |=>
		pace_o.sync_mode == (($past(dat_i) & 32'h0000_000F) != 32'h0)) else $error("sync mode wrong");
	cover property (rd_cause && ack_o && irq_o);
	cover property (seq_evt_i.valid);
	cover property (pace_o.limit && pace_o.send_stall);
endmodule : sciss_properties
bind sciss_top sciss_properties i_sciss_properties (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .sel_i, .dat_i, .ack_o, .cmd_write_i, .cmd_illegal_i, .seq_evt_i, .irq_o,
	.sel_timeout_o, .pace_o);
`default_nettype wire

// ---- sim/testbench.sv ----
/* Self-checking bench for sciss_top with the far side model.
 * Assumes the port checker binds itself to sciss_top. */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sciss_pkg::*;
;
	logic	clk_i, rst_i, cyc_i, stb_i, we_i, target_mode_i, atn_i, ack_o, irq_o, atn_hold_o;
	logic [5:0]	adr_i, pls;
	logic [3:0]	sel_i;
	logic [31:0]	dat_i, dat_o, rng;
	logic [7:0]	q, sel_timeout_o;
	wire logic	cmd_write_i, cmd_illegal_i, tx_byte_i, ack_in_i, fifo_pop_i, offset_clr_i;
	sciss_seq_evt_t	seq_evt_i;
	sciss_bus_evt_t	bus_evt_i;
	sciss_pace_t	pace_o;
	int	bad_count, total_checks;
	localparam logic [6:0] TBL [21] = '{7'h08, 7'h09, 7'h0A, 7'h0D, 7'h01, 7'h05, 7'h12,
		7'h15, 7'h19, 7'h23, 7'h25, 7'h2D, 7'h33, 7'h35, 7'h3D, 7'h45, 7'h4D, 7'h00, 7'h11,
		7'h3C, 7'h44};
	localparam logic [7:0] PIN_CAUSE [5] = '{8'h80, 8'h04, 8'h20, 8'h10, 8'h08};
	assign {cmd_write_i, cmd_illegal_i, tx_byte_i, ack_in_i, fifo_pop_i, offset_clr_i} = pls;
	sciss_top i_sciss_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .target_mode_i, .cmd_write_i, .cmd_illegal_i, .atn_i, .seq_evt_i, .bus_evt_i,
		.tx_byte_i, .ack_in_i, .fifo_pop_i, .offset_clr_i, .irq_o, .atn_hold_o, .sel_timeout_o,
		.pace_o);
	sciss_bus_model i_sciss_bus_model (.clk_i, .seq_o(seq_evt_i), .bus_o(bus_evt_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	function automatic logic [5:0] exp_period(input logic [4:0] c);
		return (c < 5'h04) ? {1'b1, c} : (c == 5'h04) ? 6'h05 : {1'b0, c};
	endfunction : exp_period
	// packs {atn hold, step, cause}
	function automatic logic [11:0] exp_rep(input sciss_seq_t s, input sciss_end_t h,
		input logic [1:0] b, input logic a);
		logic [2:0] st;
		logic [7:0] c;
		logic hd;
		st = (h == SCISS_END_PARITY) ? 3'h1 : (h == SCISS_END_PREMAT) ? 3'h3 : 3'h2;
		if (h == SCISS_END_DONE && s <= SCISS_SQ_SEL_ATN3) st = 3'h4;
		if (s == SCISS_SQ_SEL_ATN_STOP) st = (h == SCISS_END_DONE) ? 3'h1 : 3'h0;
		c = (s <= SCISS_SQ_SEL_ATN3) ? 8'h18 : (s == SCISS_SQ_TGT_SEL) ? 8'h01 :
			(s == SCISS_SQ_TGT_SEL_ATN) ? 8'h02 : (s == SCISS_SQ_TGT_RXCMD) ? 8'h08 : 8'h28;
		if (a) c |= 8'h10;
		hd = (s == SCISS_SQ_SEL_ATN_STOP)
			|| (s == SCISS_SQ_SEL_ATN3 && h == SCISS_END_NOPHASE && b != 2'h3);
		// stopped before any message byte: step 000 and ATN still driven
		if (s != SCISS_SQ_SEL && s <= SCISS_SQ_SEL_ATN3 && h == SCISS_END_NOPHASE
				&& b == 2'h0) begin
			st = 3'h0;
			hd = 1'b1;
		end
		// target stopped by ATN after one or two bytes
		if (s >= SCISS_SQ_TGT_DISC && h != SCISS_END_DONE) begin
			st = {2'h0, b == 2'h2};
			c  = 8'h18;
		end
		if (h == SCISS_END_TIMEOUT) return 12'h020;
		return {hd, st, c};
	endfunction : exp_rep
	task automatic chk(input logic [7:0] e, input logic [7:0] g, input string n);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d, input logic [3:0] s);
		{cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, s};
		adr_i <= {i, 2'b00};
		dat_i <= {24'h0, d};
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [3:0] i, input logic [7:0] e, input string n);
		wb(1'b0, i, 8'h00, 4'hF);
		chk(e, q, n);
	endtask : rd
	task automatic pulse(input logic [5:0] m);
		pls <= m;
		@(posedge clk_i);
		pls <= 6'h00;
		@(posedge clk_i);
	endtask : pulse
	task automatic expect_irq(input logic [7:0] c, input logic [2:0] st);
		repeat (8) @(posedge clk_i);
		chk(8'h01, {7'h0, irq_o}, "irq");
		rd(SCISS_IDX_STEP, {5'h0, st}, "step");
		rd(SCISS_IDX_STATUS, 8'h80, "status");
		rd(SCISS_IDX_CAUSE, c, "cause");
		rd(SCISS_IDX_STEP, 8'h00, "step cleared");
		rd(SCISS_IDX_STATUS, 8'h00, "status cleared");
		chk(8'h00, {7'h0, irq_o}, "irq cleared");
	endtask : expect_irq
	task automatic stop_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end
	initial begin
		logic [11:0] r;
		sciss_seq_t s;
		sciss_end_t h;
		logic [1:0] b;
		logic a;
		logic [7:0] d;
		{rst_i, cyc_i, stb_i, we_i, target_mode_i, atn_i} = 6'h20;
		{adr_i, pls, sel_i, dat_i} = '0;
		rng = 32'hEE83F82E;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(8'h05, {2'h0, pace_o.period}, "period reset");
		rd(SCISS_IDX_CAUSE, 8'h00, "cause reset");
		rd(4'h1, 8'h00, "unmapped");
		for (int k = 0; k < 32; k++) begin
			wb(1'b1, SCISS_IDX_PERIOD, 8'(k), 4'hF);
			chk({2'h0, exp_period(5'(k))}, {2'h0, pace_o.period}, "period");
		end
		wb(1'b1, SCISS_IDX_PERIOD, 8'h04, 4'h0);
		chk(8'h1F, {2'h0, pace_o.period}, "period unselected");
		d = 8'(xs());
		wb(1'b1, SCISS_IDX_CAUSE, d, 4'hF);
		chk(d, sel_timeout_o, "timeout");
		rd(SCISS_IDX_CAUSE, 8'h00, "timeout readback");
		for (int k = 0; k < 40; k++) begin
			d = {1'b0, TBL[k < 21 ? k : int'(xs() % 21)]};
			s = sciss_seq_t'(d[6:3]);
			h = sciss_end_t'(d[2:0]);
			b = (s == SCISS_SQ_SEL_ATN3) ? 2'(1 + xs() % 3) :
				(s >= SCISS_SQ_TGT_DISC) ? 2'(1 + xs() % 2) :
				(s == SCISS_SQ_SEL_ATN) ? 2'(xs() % 2) :
				{1'b0, s == SCISS_SQ_SEL_ATN_STOP && h == SCISS_END_DONE};
			a = s >= SCISS_SQ_TGT_SEL && s <= SCISS_SQ_TGT_RXCMD && xs() % 2 == 1;
			target_mode_i <= s >= SCISS_SQ_TGT_SEL;
			atn_i <= a;
			i_sciss_bus_model.seq(s, h, b, a);
			r = exp_rep(s, h, b, a);
			repeat (2) @(posedge clk_i);
			chk({7'h0, r[11]}, {7'h0, atn_hold_o}, "atn hold");
			expect_irq(r[7:0], r[10:8]);
		end
		target_mode_i <= 1'b0;
		atn_i <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			// one-cycle blips never reach two agreeing stages, so hold two or more
			i_sciss_bus_model.pin(4 - k, 2 + int'(xs() % 7));
			expect_irq(PIN_CAUSE[k], 3'h0);
		end
		target_mode_i <= 1'b1;
		atn_i <= 1'b1;
		i_sciss_bus_model.pin(0, 3);
		expect_irq(8'h10, 3'h0);
		target_mode_i <= 1'b0;
		atn_i <= 1'b0;
		wb(1'b1, SCISS_IDX_CTRL, 8'h01, 4'hF);
		rd(SCISS_IDX_CTRL, 8'h01, "reset report off");
		i_sciss_bus_model.pin(4, 2);
		repeat (8) @(posedge clk_i);
		rd(SCISS_IDX_CAUSE, 8'h00, "bus reset masked");
		wb(1'b1, SCISS_IDX_CTRL, 8'h00, 4'hF);
		pulse(6'h20);
		chk(8'h00, {7'h0, irq_o}, "legal command");
		pulse(6'h30);
		expect_irq(8'h40, 3'h0);
		// offset of two: two sends reach the limit, one ack frees a slot
		wb(1'b1, SCISS_IDX_OFFSET, 8'h02, 4'hF);
		pulse(6'h08);
		pulse(6'h08);
		@(posedge clk_i);
		chk(8'h07, {5'h0, pace_o.sync_mode, pace_o.send_stall, pace_o.limit}, "at limit");
		rd(SCISS_IDX_STEP, 8'h08, "step limit");
		pulse(6'h04);
		@(posedge clk_i);
		chk(8'h04, {5'h0, pace_o.sync_mode, pace_o.send_stall, pace_o.limit}, "acked");
		pulse(6'h02);
		chk(8'h01, {7'h0, pace_o.rx_ack}, "rx ack");
		pulse(6'h01);
		wb(1'b1, SCISS_IDX_OFFSET, 8'h00, 4'hF);
		chk(8'h00, {7'h0, pace_o.sync_mode}, "async");
		// reset in mid-run with a cause posted and a long period loaded
		pulse(6'h30);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(8'h00, {7'h0, irq_o}, "irq after reset");
		chk(8'h05, {2'h0, pace_o.period}, "period after reset");
		rd(SCISS_IDX_CAUSE, 8'h00, "cause after reset");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
